/* design/iepbc_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - enable rides a differential carrier across transformer
// - secondary decodes carrier and drives gate
// - two-wire: enable high powers, gate waits
// - two-wire: enable low drops gate, stops power
// - three-wire: power bursts regardless of enable
// - three-wire with power: gate follows enable
// - standard variant: gate tracks enable level
// - one-shot: each rising edge gives one pulse
// - one-shot rearms only after enable low
// - three-wire: repeating bursts while supply present
// - constant period, on-time grows with setting
// - seven duty cycles 13.3% to 93.3%
// - setting caught at power-up, then held
// - clamp gate low when secondary power lost
// - one-shot pulse lasts 2.5 us
// - out-of-range setting falls back to lowest
// - wire mode caught at power-up, then held
// - rail undervoltage forces gate low
module iepbc_ctrl
   import iepbc_pkg::*;
#(
   parameter int unsigned SLOT_CYCLES    = SLOT_CYC,
   parameter int unsigned ONE_SHOT_CYCLES = ONE_SHOT_CYC
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        en_in,
   input  wire logic        three_wire_in,
   input  wire logic        one_shot_in,
   input  wire logic [2:0]  power_level_select_in,
   input  wire logic        secondary_rails_ok_in,
   output iepbc_link_t      carrier_out,
   output logic             power_xfer_out,
   output logic             gate_drive_out,
   output logic             keep_off_clamp_out,
   output logic [2:0]       power_level_out
);
   iepbc_strap_t strap, next_strap;
   iepbc_burst_t burst, next_burst;
   logic [11:0]  slot_cnt, next_slot_cnt;
   logic [3:0]   slot_idx, next_slot_idx;
   logic         en_q, next_en_q;
   logic         armed, next_armed;
   logic [11:0]  pulse_cnt, next_pulse_cnt;
   logic         decoded, next_decoded;
   logic         car, next_car;
   logic         gate, next_gate;
   logic         xfer;
   logic         tx_on;
   logic         fire;

   function automatic logic [3:0] on_slots(input logic [2:0] lvl);
      on_slots = {lvl, 1'b0} + 4'h2;
   endfunction : on_slots

   function automatic logic [2:0] clip_level(input logic [2:0] raw);
      clip_level = (raw > LEVEL_MAX) ? LEVEL_RST : raw;
   endfunction : clip_level

   // straps, captured on every reset cycle and frozen afterwards
   always_comb begin
      next_strap = strap;
      if (rst_in) begin
         next_strap.three_wire = three_wire_in;
         next_strap.one_shot   = one_shot_in & three_wire_in;
         next_strap.level      = clip_level(power_level_select_in);
      end
   end

   always_ff @(posedge clk_in) begin
      strap <= next_strap;
   end

   // burst timer for three-wire power transfer
   always_comb begin
      next_burst    = burst;
      next_slot_cnt = slot_cnt;
      next_slot_idx = slot_idx;
      if (slot_cnt == 12'(SLOT_CYCLES - 1)) begin
         next_slot_cnt = 12'h000;
         if (slot_idx == 4'(BURST_SLOTS - 1)) begin
            next_slot_idx = 4'h0;
         end else begin
            next_slot_idx = slot_idx + 4'h1;
         end
      end else begin
         next_slot_cnt = slot_cnt + 12'h001;
      end
      // on while index below the level-dependent count
      if (next_slot_idx < on_slots(strap.level)) begin
         next_burst = BURST_ON;
      end else begin
         next_burst = BURST_OFF;
      end
      if (rst_in) begin
         next_burst    = BURST_ON;
         next_slot_cnt = 12'h000;
         next_slot_idx = 4'h0;
      end
   end

   always_ff @(posedge clk_in) begin
      burst    <= next_burst;
      slot_cnt <= next_slot_cnt;
      slot_idx <= next_slot_idx;
   end

   // power transfer: bursts in three-wire, follows enable in two-wire
   always_comb begin
      if (strap.three_wire) begin
         xfer = (burst == BURST_ON);
      end else begin
         xfer = en_q;
      end
   end

   // carrier runs for power and also to send a pending enable change
   assign tx_on = xfer | (en_q != decoded);

   // primary transmitter and secondary demodulator
   always_comb begin
      next_en_q    = en_in;
      next_car     = tx_on ? ~car : 1'b0;
      next_decoded = decoded;
      if (tx_on) begin
         next_decoded = en_q;
      end else if (!strap.three_wire) begin
         next_decoded = 1'b0;
      end
      if (rst_in) begin
         next_en_q    = 1'b0;
         next_car     = 1'b0;
         next_decoded = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      en_q    <= next_en_q;
      car     <= next_car;
      decoded <= next_decoded;
   end

   // one-shot: rising edge of decoded enable while armed
   assign fire = strap.one_shot & decoded & armed;

   always_comb begin
      next_armed     = armed;
      next_pulse_cnt = pulse_cnt;
      if (!decoded) begin
         next_armed = 1'b1;
      end else if (fire) begin
         next_armed = 1'b0;
      end
      if (fire) begin
         next_pulse_cnt = 12'(ONE_SHOT_CYCLES);
      end else if (pulse_cnt != 12'h000) begin
         next_pulse_cnt = pulse_cnt - 12'h001;
      end
      if (rst_in) begin
         next_armed     = 1'b0;
         next_pulse_cnt = 12'h000;
      end
   end

   always_ff @(posedge clk_in) begin
      armed     <= next_armed;
      pulse_cnt <= next_pulse_cnt;
   end

   // gate driver
   always_comb begin
      if (!secondary_rails_ok_in) begin
         next_gate = 1'b0;
      end else if (strap.one_shot) begin
         next_gate = fire | (pulse_cnt > 12'h001);
      end else begin
         next_gate = decoded;
      end
      if (rst_in) begin
         next_gate = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      gate <= next_gate;
   end

   assign carrier_out.p      = car;
   assign carrier_out.n      = tx_on & ~car;
   assign power_xfer_out     = xfer;
   assign gate_drive_out     = gate;
   assign keep_off_clamp_out = ~secondary_rails_ok_in;
   assign power_level_out    = strap.level;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   chk_two_wire_low: assert property (
      !strap.three_wire && !en_q ##1 !en_q |-> !xfer ##1 !gate)
      else $error("two-wire low enable left gate or power on");
   chk_three_wire_power: assert property (
      strap.three_wire && slot_idx == 4'h0 |-> xfer)
      else $error("three-wire burst missing at period start");
   chk_uvlo_gate: assert property (
      !secondary_rails_ok_in |=> !gate)
      else $error("gate high during rail undervoltage");
   chk_std_follow: assert property (
      !strap.one_shot && secondary_rails_ok_in && $rose(en_q)
      ##1 secondary_rails_ok_in |=> gate)
      else $error("standard gate did not follow enable");
   // pulse must still stand eight cycles after the trigger
   chk_oneshot_len: assert property (
      fire ##0 secondary_rails_ok_in [*8] |=> gate)
      else $error("one-shot pulse ended early");
   chk_oneshot_end: assert property (
      fire |-> ##[1:1000] !gate)
      else $error("one-shot pulse did not end");
   chk_rearm_low: assert property (
      strap.one_shot && $fell(gate) && decoded |=> !fire)
      else $error("one-shot retriggered without low enable");
   chk_level_range: assert property (
      power_level_out <= LEVEL_MAX)
      else $error("power level out of range");
   chk_level_hold: assert property (
      ##1 $stable(strap))
      else $error("straps changed after power-up");
   chk_carrier_diff: assert property (
      tx_on |-> carrier_out.p != carrier_out.n ##1
         carrier_out.p != $past(carrier_out.p))
      else $error("carrier not toggling differentially");

   cov_oneshot: cover property (fire ##[1:300] !gate);
   cov_two_wire: cover property (!strap.three_wire && $rose(gate));
   cov_burst_off: cover property (strap.three_wire && $fell(xfer));
   cov_uvlo: cover property (gate ##1 !secondary_rails_ok_in);
endmodule : iepbc_ctrl

/* design/iepbc_pkg.sv */
package iepbc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   // carrier nominal rate; the clock-rate model toggles every CARRIER_DIV
   localparam int unsigned CARRIER_MHZ   = 89;
   localparam int unsigned CARRIER_DIV   = 1;
   // burst on-interval nominal length at the lowest setting
   localparam int unsigned BURST_ON_NS   = 25000;
   // period is 15 slots, on-time is 2*(level+1) slots: 13.3% .. 93.3%
   localparam int unsigned BURST_SLOTS   = 15;
   localparam int unsigned SLOT_NS       = BURST_ON_NS / 2;
   localparam int unsigned SLOT_CYC      =
      (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ONE_SHOT_NS   = 2500;
   localparam int unsigned ONE_SHOT_CYC  = ONE_SHOT_NS / CLK_PERIOD_NS;
   localparam logic [2:0]  LEVEL_MAX     = 3'h6;
   localparam logic [2:0]  LEVEL_RST     = 3'h0;

   typedef struct packed {
      logic p;
      logic n;
   } iepbc_link_t;

   typedef struct packed {
      logic       three_wire;
      logic       one_shot;
      logic [2:0] level;
   } iepbc_strap_t;

   typedef enum logic [1:0] {
      BURST_OFF = 2'b01,
      BURST_ON  = 2'b10
   } iepbc_burst_t;
endpackage : iepbc_pkg

/* verification/iepbc_host.sv */
`timescale 1ns/1ps
module iepbc_host (
   input  wire logic clk_in,
   input  wire logic want_in,
   input  wire logic gate_in,
   output logic      en_out,
   output logic      switch_on_out
);
   // enable changes only just after an edge, copying want_in one clock later
   always @(posedge clk_in) begin
      en_out <= want_in;
   end
   // the external switch conducts while its gate is driven
   assign switch_on_out = gate_in;
endmodule : iepbc_host

/* verification/iepbc_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module isolated_enable_power_burst_ctrl_bench;
   import iepbc_pkg::*;
   localparam int SC = 4;
   localparam int OC = 10;
   logic        clk_in;
   logic        rst_in;
   logic        want;
   logic        en;
   logic        tw;
   logic        os;
   logic        ok;
   logic [2:0]  sel;
   iepbc_link_t car;
   logic        px;
   logic        gate;
   logic        clamp;
   logic        sw;
   logic [2:0]  lvl;
   int          err_total;
   int          checks_done;
   int          n;
   int          c;

   iepbc_ctrl #(.SLOT_CYCLES(SC), .ONE_SHOT_CYCLES(OC)) DUT (
      .clk_in(clk_in), .rst_in(rst_in), .en_in(en), .three_wire_in(tw),
      .one_shot_in(os), .power_level_select_in(sel),
      .secondary_rails_ok_in(ok), .carrier_out(car), .power_xfer_out(px),
      .gate_drive_out(gate), .keep_off_clamp_out(clamp),
      .power_level_out(lvl));
   iepbc_host HOST (.clk_in(clk_in), .want_in(want), .gate_in(gate),
      .en_out(en), .switch_on_out(sw));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task end_sim;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim

   task boot(input logic t, input logic o, input logic [2:0] l);
      @(posedge clk_in);
      rst_in <= 1'b1; tw <= t; os <= o; sel <= l; want <= 1'b0; ok <= 1'b1;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
   endtask : boot

   task waitg(input logic v);
      n = 0;
      while (gate !== v && n < 200) begin
         @(negedge clk_in);
         n++;
      end
      if (gate !== v) begin
         err_total++;
         end_sim();
      end
   endtask : waitg

   task count_hi(input logic use_gate, input int len);
      c = 0;
      repeat (len) begin
         @(negedge clk_in);
         c += use_gate ? (gate === 1'b1) : (px === 1'b1);
      end
   endtask : count_hi

   task t_two_wire;
      boot(1'b0, 1'b0, 3'h3);
      @(negedge clk_in);
      `CHK(lvl, 3'h3)
      `CHK(px, 1'b0)
      `CHK(car, 2'b00)
      @(posedge clk_in) want <= 1'b1;
      waitg(1'b1);
      `CHK(px, 1'b1)
      `CHK(car.p ^ car.n, 1'b1)
      `CHK(sw, 1'b1)
      @(posedge clk_in) ok <= 1'b0;
      @(posedge clk_in);
      @(negedge clk_in);
      `CHK(gate, 1'b0)
      `CHK(clamp, 1'b1)
      @(posedge clk_in) ok <= 1'b1;
      waitg(1'b1);
      @(posedge clk_in) begin
         want <= 1'b0;
         tw <= 1'b1;
      end
      waitg(1'b0);
      count_hi(1'b0, 20);
      `CHK(c, 0)
   endtask : t_two_wire

   task t_bursts;
      for (int l = 0; l < 8; l++) begin
         boot(1'b1, 1'b0, l[2:0]);
         @(posedge clk_in) sel <= 3'h5;
         count_hi(1'b0, 15 * SC);
         `CHK(c, 2 * ((l == 7 ? 0 : l) + 1) * SC)
         `CHK(lvl, (l == 7) ? 3'h0 : l[2:0])
      end
   endtask : t_bursts

   task t_three_std;
      boot(1'b1, 1'b0, 3'h6);
      // host edge, then en_q, decoded and gate: high at the fifth negedge
      @(posedge clk_in) want <= 1'b1;
      waitg(1'b1);
      `CHK(n, 5)
      @(posedge clk_in) want <= 1'b0;
      waitg(1'b0);
      `CHK(n, 5)
   endtask : t_three_std

   task t_one_shot;
      boot(1'b1, 1'b1, 3'h6);
      repeat (2) begin
         @(posedge clk_in) want <= 1'b1;
         count_hi(1'b1, 150);
         `CHK(c, OC)
         `CHK(gate, 1'b0)
         @(posedge clk_in) want <= 1'b0;
         repeat (30) @(posedge clk_in);
      end
   endtask : t_one_shot

   initial begin
      rst_in = 1'b1; want = 1'b0; tw = 1'b0; os = 1'b0; ok = 1'b1;
      sel = 3'h0; err_total = 0; checks_done = 0;
      t_two_wire();
      t_bursts();
      t_three_std();
      t_one_shot();
      end_sim();
   end
endmodule : isolated_enable_power_burst_ctrl_bench
